// file: verilog/mpc_pkg.sv
// Shared constants, field positions and state encoding for the parity memory controller.
// Notes on behaviour
// [RQ1] Answer only single, byte, read-modify-write, block dialogues.
// [RQ2] Raise module select only inside switch range.
// [RQ3] Register address picked from sixteen by switches.
// [RQ4] Arbiter picks register access, array access, refresh.
// [RQ5] Row address with row strobe, then column strobe.
// [RQ6] Refresh uses row strobe only, never column.
// [RQ7] Free-running timer requests refresh every 12 us.
// [RQ8] Eight row pulses per refresh, then row advances.
// [RQ9] Refresh rows wrap at 128 or 256.
// [RQ10] Refresh lasts 535 ns; array access waits.
// [RQ11] Block mode steps address per word, sixteen max.
// [RQ12] Writes store one parity bit per byte.
// [RQ13] Reads check parity; error lights indicator, latches address.
// [RQ14] Register bits 1,3,4,12,13 read zero, ignore writes.
// [RQ15] Bit 0 set: error drives address lines 16,17.
// [RQ16] Bit 2 set: writes store inverted parity.
// [RQ17] Error stores address 11-17, latches 18-21.
// [RQ18] Bit 14 set: reads show address 18-21.
// [RQ19] Error address survives reset, overwritten by new error.
// [RQ20] Bit 14 read/write, cleared by reset and initialize.
// [RQ21] Bit 15 sticky error flag, drives indicator.
// [RQ22] Master reads, sets bit 14, rereads, clears it.
// [RQ23] Bus initialize idles logic, clears resettable bits.
// [RQ24] Access during refresh is answered after refresh.
package mpc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int REF_INTERVAL_NS = 12000;
    localparam int REF_INTERVAL_CYC = REF_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int REF_TIME_NS = 535;
    localparam int REF_CYC = (REF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_PULSES = 8;
    localparam int ROWS_SMALL = 128;
    localparam int ROWS_BIG = 256;
    localparam int BLOCK_MAX = 16;

    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int DRAM_AW = 9;
    localparam int BANKS = 8;
    localparam int SW_W = 9;
    localparam int SW_LSB = 13;
    localparam int SYNC_W = 7 + ADDR_W + SW_W + SW_W + 4 + 1;

    // Word address fields of the array for both chip sizes.
    localparam int SMALL_ROW_W = 8;
    localparam int SMALL_COL_LSB = 8;
    localparam int SMALL_BANK_LSB = 16;
    localparam int BIG_COL_LSB = 9;
    localparam int BIG_BANK_LSB = 18;

    // Register placement in the I/O page and its field layout.
    localparam logic [12:0] CSR_BASE = 13'h1440;
    localparam int CSR_PEN = 0;
    localparam int CSR_WWP = 2;
    localparam int CSR_EA_LSB = 5;
    localparam int CSR_EA_LO_W = 7;
    localparam int CSR_EA_HI_W = 4;
    localparam int CSR_EXT = 14;
    localparam int CSR_ERR = 15;
    localparam int ADDR_EA_LO_LSB = 11;
    localparam int ADDR_EA_HI_LSB = 18;
    localparam int BDAL_PERR_LSB = 16;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ROW = 3'h1,
        ST_COL = 3'h3,
        ST_DATA = 3'h2,
        ST_DONE = 3'h6,
        ST_CSR = 3'h7,
        ST_REF = 3'h4
    } mpc_state_t;
endpackage

// file: verilog/mpc_ref_if.sv
// Refresh request, completion and row between the controller and its refresh timer.
`timescale 1ns/1ps
interface mpc_ref_if;
    logic req;
    logic done;
    logic [7:0] row;
    modport ctl (input req, input row, output done);
    modport tmr (output req, output row, input done);
endinterface

// file: verilog/mpc_refresh.sv
// Free-running refresh timer and refresh row counter.
`timescale 1ns/1ps
module mpc_refresh
    import mpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic big_chip,
    mpc_ref_if.tmr rif
);
    localparam logic [8:0] TMR_LAST = 9'(REF_INTERVAL_CYC - 1);

    logic [8:0] tmr_q;
    logic req_q;
    logic [7:0] row_q;
    wire tick = (tmr_q == TMR_LAST);
    wire [7:0] row_last = big_chip ? 8'(ROWS_BIG - 1) : 8'(ROWS_SMALL - 1);

    // The timer never stops for bus traffic; a pending request simply waits for the arbiter.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_q <= 9'h000;
            req_q <= 1'b0;
            row_q <= 8'h00;
        end else begin
            tmr_q <= tick ? 9'h000 : tmr_q + 9'h001; // [RQ7]
            if (tick) begin
                req_q <= 1'b1; // [RQ7]
            end else if (rif.done) begin
                req_q <= 1'b0;
            end
            if (rif.done) begin
                row_q <= (row_q >= row_last) ? 8'h00 : row_q + 8'h01; // [RQ8] [RQ9]
            end
        end
    end

    assign rif.req = req_q;
    assign rif.row = row_q;
endmodule

// file: verilog/mpc_parity.sv
// Byte parity generation for writes and checking for reads.
`timescale 1ns/1ps
module mpc_parity
    import mpc_pkg::*;
(
    input wire logic [DATA_W-1:0] wdata,
    input wire logic invert,
    input wire logic [DATA_W+1:0] rdata,
    output logic [1:0] wpar,
    output logic [1:0] perr
);
    // Odd parity per byte: a stuck-at-zero array reads back as an error.
    assign wpar[0] = ~(^wdata[7:0]) ^ invert; // [RQ12] [RQ16]
    assign wpar[1] = ~(^wdata[15:8]) ^ invert; // [RQ12] [RQ16]
    assign perr[0] = ~(^{rdata[16], rdata[7:0]}); // [RQ13]
    assign perr[1] = ~(^{rdata[17], rdata[15:8]}); // [RQ13]
endmodule

// file: verilog/mpc_ctrl.sv
// Bus slave, cycle arbiter, array sequencer and parity status register of the memory board.
`timescale 1ns/1ps
module mpc_ctrl
    import mpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic bus_sync_n,
    input wire logic bus_din_n,
    input wire logic bus_dout_n,
    input wire logic bus_wtbt_n,
    input wire logic bus_bs7_n,
    input wire logic bus_bref_n,
    input wire logic bus_init_n,
    input wire logic [ADDR_W-1:0] bdal_in,
    output logic [ADDR_W-1:0] bdal_out,
    output logic [ADDR_W-1:0] bdal_oe,
    output logic bus_rply_out,
    output logic bus_rply_oe,
    input wire logic [SW_W-1:0] start_addr_sw,
    input wire logic [SW_W-1:0] end_addr_sw,
    input wire logic [3:0] csr_sel_sw,
    input wire logic big_chip,
    output logic [DRAM_AW-1:0] dram_addr,
    output logic [BANKS-1:0] dram_ras_n,
    output logic dram_cas_n,
    output logic [1:0] dram_we_n,
    output logic [DATA_W+1:0] dram_wdata,
    input wire logic [DATA_W+1:0] dram_rdata,
    output logic parity_led
);
    localparam logic [3:0] REF_LAST = 4'(REF_CYC - 1);
    localparam logic [3:0] REF_NPULSE = 4'(REF_PULSES);
    localparam logic [4:0] BLK_LIMIT = 5'(BLOCK_MAX);

    // Every bus pin is asynchronous to core_clk, including the static switches.
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    wire [SYNC_W-1:0] raw_in = {~bus_sync_n, ~bus_din_n, ~bus_dout_n, ~bus_wtbt_n, ~bus_bs7_n, ~bus_bref_n,
                                ~bus_init_n, bdal_in, start_addr_sw, end_addr_sw, csr_sel_sw, big_chip};

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    // Unpack the synchronised vector.
    wire sync_s = sync2_q[SYNC_W-1];
    wire din_s = sync2_q[SYNC_W-2];
    wire dout_s = sync2_q[SYNC_W-3];
    wire wtbt_s = sync2_q[SYNC_W-4];
    wire bs7_s = sync2_q[SYNC_W-5];
    wire bref_s = sync2_q[SYNC_W-6];
    wire init_s = sync2_q[SYNC_W-7];
    wire [ADDR_W-1:0] bdal_s = sync2_q[SYNC_W-8 -: ADDR_W];
    wire [SW_W-1:0] start_s = sync2_q[SW_W+5 +: SW_W];
    wire [SW_W-1:0] end_s = sync2_q[5 +: SW_W];
    wire [3:0] csr_sel_s = sync2_q[4:1];
    wire big_s = sync2_q[0];

    mpc_state_t state_q;
    mpc_state_t state_d;
    logic sync_prev_q;
    logic [ADDR_W-1:0] addr_q;
    logic mem_hit_q;
    logic csr_hit_q;
    logic wr_q;
    logic byte_q;
    logic blk_q;
    logic [4:0] blk_cnt_q;
    logic [3:0] ref_cnt_q;
    logic pen_q;
    logic wwp_q;
    logic ext_q;
    logic err_q;
    logic [CSR_EA_LO_W-1:0] ea_lo_q;
    logic [CSR_EA_HI_W-1:0] ea_hi_q;
    logic [DATA_W+1:0] wdata_q;
    logic [DRAM_AW-1:0] dram_addr_q;
    logic [DATA_W-1:0] rdout_q;
    logic perr_flag_q;
    logic [1:0] wpar;
    logic [1:0] perr;
    logic [DATA_W-1:0] csr_rd;

    mpc_ref_if rif ();

    mpc_refresh u_refresh (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .big_chip(big_s),
        .rif(rif.tmr)
    );

    mpc_parity u_parity (
        .wdata(bdal_s[DATA_W-1:0]),
        .invert(wwp_q),
        .rdata(dram_rdata),
        .wpar(wpar),
        .perr(perr)
    );

    // Address decode at the leading edge of the address strobe.
    wire sync_rise = sync_s & ~sync_prev_q;
    wire [SW_W-1:0] seg = bdal_s[SW_LSB +: SW_W];
    wire mem_dec = ~bs7_s & (seg >= start_s) & (seg < end_s); // [RQ2]
    wire [12:0] csr_addr = CSR_BASE + {8'h00, csr_sel_s, 1'b0}; // [RQ3]
    // Word compare only, so a byte write to the odd address still reaches the upper half.
    wire csr_dec = bs7_s & (bdal_s[12:1] == csr_addr[12:1]); // [RQ3]
    wire module_select = mem_hit_q;

    // Only din or dout inside an address strobe starts a cycle; interrupt and other dialogues are ignored.
    wire strobe = sync_s & (din_s | dout_s); // [RQ1]
    wire blk_full = (blk_cnt_q == BLK_LIMIT); // [RQ11]
    wire ref_last = (ref_cnt_q == REF_LAST);
    wire acc_ras = (state_q == ST_ROW) | (state_q == ST_COL) | (state_q == ST_DATA);
    wire acc_cas = (state_q == ST_COL) | (state_q == ST_DATA);
    wire ref_ras = (state_q == ST_REF) & (ref_cnt_q < REF_NPULSE);
    wire par_event = (state_q == ST_DATA) & ~wr_q & (|perr); // [RQ13]

    // Array address fields for the fitted chip size.
    wire [ADDR_W-2:0] waddr = addr_q[ADDR_W-1:1];
    wire [DRAM_AW-1:0] row_a = big_s ? waddr[DRAM_AW-1:0] : {1'b0, waddr[SMALL_ROW_W-1:0]};
    wire [DRAM_AW-1:0] col_a = big_s ? waddr[BIG_COL_LSB +: DRAM_AW] : {1'b0, waddr[SMALL_COL_LSB +: SMALL_ROW_W]};
    wire [2:0] bank_a = big_s ? waddr[BIG_BANK_LSB +: 3] : waddr[SMALL_BANK_LSB +: 3];

    // Arbiter: a pending refresh goes first, so a bus access that meets it waits for its reply.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (rif.req) begin
                    state_d = ST_REF; // [RQ4] [RQ10] [RQ24]
                end else if (strobe & csr_hit_q) begin
                    state_d = ST_CSR; // [RQ4]
                end else if (strobe & module_select & ~blk_full) begin
                    state_d = ST_ROW; // [RQ4] [RQ11]
                end
            end
            ST_ROW: state_d = ST_COL; // [RQ5]
            ST_COL: state_d = ST_DATA;
            ST_DATA: state_d = ST_DONE;
            ST_CSR: state_d = ST_DONE;
            ST_DONE: begin
                if (~din_s & ~dout_s) begin
                    state_d = ST_IDLE;
                end
            end
            ST_REF: begin
                if (ref_last) begin
                    state_d = ST_IDLE; // [RQ10]
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Array multiplexer: row with the row strobe, column with the column strobe, both from the same clock edge.
    wire [DRAM_AW-1:0] dram_addr_d = (state_d == ST_ROW) ? row_a :
                                     ((state_d == ST_COL) | (state_d == ST_DATA)) ? col_a :
                                     (state_d == ST_REF) ? {1'b0, rif.row} : dram_addr_q; // [RQ5] [RQ8]

    // Sequencer state, strobe edge and refresh counter; bus initialize returns the sequencer to idle.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            sync_prev_q <= 1'b0;
            ref_cnt_q <= 4'h0;
        end else begin
            sync_prev_q <= sync_s;
            state_q <= init_s ? ST_IDLE : state_d; // [RQ23]
            ref_cnt_q <= (state_q == ST_REF) ? ref_cnt_q + 4'h1 : 4'h0;
        end
    end

    // Address latch, hit flags and block stepping.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_q <= '0;
            mem_hit_q <= 1'b0;
            csr_hit_q <= 1'b0;
            blk_cnt_q <= 5'h00;
        end else if (sync_rise) begin
            addr_q <= bdal_s;
            mem_hit_q <= mem_dec; // [RQ2]
            csr_hit_q <= csr_dec;
            blk_cnt_q <= 5'h00;
        end else if ((state_q == ST_DONE) & (state_d == ST_IDLE) & blk_q & mem_hit_q) begin
            addr_q <= addr_q + 22'h000002; // [RQ11]
            blk_cnt_q <= blk_cnt_q + 5'h01; // [RQ11]
        end
    end

    // Cycle type and write data are caught when the arbiter starts a cycle.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= 1'b0;
            byte_q <= 1'b0;
            blk_q <= 1'b0;
            wdata_q <= '0;
        end else if ((state_q == ST_IDLE) & (state_d != ST_IDLE) & (state_d != ST_REF)) begin
            wr_q <= dout_s;
            byte_q <= dout_s & wtbt_s;
            blk_q <= bref_s;
            wdata_q <= {wpar, bdal_s[DATA_W-1:0]}; // [RQ12] [RQ16]
        end
    end

    // Read data and the parity flag travel back to the bus from flops.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdout_q <= '0;
            perr_flag_q <= 1'b0;
            dram_addr_q <= '0;
        end else begin
            dram_addr_q <= dram_addr_d;
            if (state_q == ST_DATA) begin
                rdout_q <= dram_rdata[DATA_W-1:0];
                perr_flag_q <= par_event & pen_q; // [RQ15]
            end else if (state_q == ST_CSR) begin
                rdout_q <= csr_rd;
                perr_flag_q <= 1'b0;
            end
        end
    end

    // Register writes honour the byte lanes of a byte write, except the error address field, which the low lane writes whole.
    wire csr_wr = (state_q == ST_CSR) & wr_q;
    wire wr_lo = csr_wr & (~byte_q | ~addr_q[0]);
    wire wr_hi = csr_wr & (~byte_q | addr_q[0]);
    wire [DATA_W-1:0] wd = bdal_s[DATA_W-1:0];

    // Control bits clear on reset and on bus initialize; a new error beats a write of zero.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pen_q <= 1'b0;
            wwp_q <= 1'b0;
            ext_q <= 1'b0;
            err_q <= 1'b0;
        end else if (init_s) begin
            pen_q <= 1'b0; // [RQ23] [RQ15]
            wwp_q <= 1'b0; // [RQ16]
            ext_q <= 1'b0; // [RQ20]
            err_q <= 1'b0; // [RQ21]
        end else begin
            if (wr_lo) begin
                pen_q <= wd[CSR_PEN]; // [RQ15]
                wwp_q <= wd[CSR_WWP]; // [RQ16]
            end
            if (wr_hi) begin
                ext_q <= wd[CSR_EXT]; // [RQ20]
            end
            if (par_event) begin
                err_q <= 1'b1; // [RQ21]
            end else if (wr_hi) begin
                err_q <= wd[CSR_ERR]; // [RQ21]
            end
        end
    end

    // The error address has no reset so that it survives a restart for post-mortem reads.
    always_ff @(posedge core_clk) begin
        if (par_event) begin
            ea_lo_q <= addr_q[ADDR_EA_LO_LSB +: CSR_EA_LO_W]; // [RQ17] [RQ19]
            ea_hi_q <= addr_q[ADDR_EA_HI_LSB +: CSR_EA_HI_W]; // [RQ17] [RQ19]
        end else if (wr_lo & ext_q) begin
            ea_hi_q <= wd[CSR_EA_LSB +: CSR_EA_HI_W]; // [RQ19]
        end else if (wr_lo) begin
            ea_lo_q <= wd[CSR_EA_LSB +: CSR_EA_LO_W]; // [RQ19]
        end
    end

    // Register read view; unused bit positions are hard zero.
    wire [CSR_EA_LO_W-1:0] ea_view = ext_q ? {3'h0, ea_hi_q} : ea_lo_q; // [RQ17] [RQ18]
    assign csr_rd = {err_q, ext_q, 2'h0, ea_view, 2'h0, wwp_q, 1'b0, pen_q}; // [RQ14]

    // Array strobes: one bank for an access, banks in turn for refresh.
    wire [BANKS-1:0] ras_vec = acc_ras ? (8'h01 << bank_a) :
                               ref_ras ? (8'h01 << ref_cnt_q[2:0]) : 8'h00; // [RQ5] [RQ6] [RQ8]
    assign dram_ras_n = ~ras_vec;
    assign dram_cas_n = ~acc_cas; // [RQ6]
    assign dram_we_n[0] = ~(acc_cas & wr_q & (~byte_q | ~addr_q[0])); // [RQ12]
    assign dram_we_n[1] = ~(acc_cas & wr_q & (~byte_q | addr_q[0])); // [RQ12]
    assign dram_wdata = wdata_q;
    assign dram_addr = dram_addr_q;
    assign rif.done = (state_q == ST_REF) & ref_last; // [RQ8]

    // Bus answer: reply and read data stand until the master drops its data strobe.
    wire rd_done = (state_q == ST_DONE) & ~wr_q;
    assign bus_rply_out = 1'b0;
    assign bus_rply_oe = (state_q == ST_DONE); // [RQ1]
    assign bdal_out = {4'h0, 2'h3, rdout_q};
    assign bdal_oe = {4'h0, {2{rd_done & perr_flag_q}}, {DATA_W{rd_done}}}; // [RQ15]
    assign parity_led = err_q; // [RQ13] [RQ21]
endmodule

// file: bench/mpc_dram_model.sv
// Behavioural memory array that sits behind the controller's row and column strobes.
`timescale 1ns/1ps
module mpc_dram_model
    import mpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic [DRAM_AW-1:0] dram_addr,
    input wire logic [BANKS-1:0] dram_ras_n,
    input wire logic dram_cas_n,
    input wire logic [1:0] dram_we_n,
    input wire logic [DATA_W+1:0] dram_wdata,
    output logic [DATA_W+1:0] dram_rdata
);
    logic [DATA_W+1:0] mem[int], w;
    logic [25:0] k = '0;
    logic [1:0] vld = 2'h0;
    // The row is taken while only the row strobe is low, and the lanes are written under the column strobe.
    always @(posedge core_clk) begin
        if (dram_cas_n && dram_ras_n != '1) k[25:9] <= {dram_ras_n, dram_addr};
        if (!dram_cas_n) k[8:0] <= dram_addr;
        vld <= !dram_cas_n ? 2'h2 : (vld != 2'h0 ? vld - 2'h1 : 2'h0);
        if (!dram_cas_n && dram_we_n != 2'b11) begin
            w = mem.exists({k[25:9], dram_addr}) ? mem[{k[25:9], dram_addr}] : '0;
            if (!dram_we_n[0]) {w[16], w[7:0]} = {dram_wdata[16], dram_wdata[7:0]};
            if (!dram_we_n[1]) {w[17], w[15:8]} = {dram_wdata[17], dram_wdata[15:8]};
            mem[{k[25:9], dram_addr}] = w;
        end
    end
    // Data holds two cycles; after that the lines show its inverse so late sampling is caught.
    always @* begin
        dram_rdata = mem.exists(k) ? mem[k] : '0;
        if (vld == 2'h0) dram_rdata = ~dram_rdata;
    end
endmodule

// file: bench/mpc_ctrl_assertions.sv
// Concurrent checks on the controller's bus reply, array strobes and error flag.
`timescale 1ns/1ps
module mpc_ctrl_assertions
    import mpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic bus_din_n,
    input wire logic bus_dout_n,
    input wire logic bus_init_n,
    input wire logic [ADDR_W-1:0] bdal_oe,
    input wire logic bus_rply_oe,
    input wire logic [BANKS-1:0] dram_ras_n,
    input wire logic dram_cas_n,
    input wire logic [1:0] dram_we_n,
    input wire logic parity_led
);
    logic [BANKS-1:0] ras_q;
    logic [8:0] gap_q;
    logic seen_q;
    logic [7:0] clr_q;
    logic ref_mark;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // A refresh shows as bank 0 then bank 1 strobing in consecutive cycles.
    assign ref_mark = (dram_ras_n == 8'hfd) && (ras_q == 8'hfe);
    // Gap between refreshes is loose because a running access may delay the start.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ras_q <= '1;
            gap_q <= '0;
            seen_q <= 1'b0;
            clr_q <= '0;
        end else begin
            ras_q <= dram_ras_n;
            gap_q <= ref_mark ? 9'h000 : gap_q + 9'h001;
            seen_q <= seen_q | ref_mark;
            clr_q <= {clr_q[6:0], !bus_dout_n || !bus_init_n};
        end
    end
    chk_ref_walk: assert property ((dram_ras_n == 8'hfe) ##1 (dram_ras_n == 8'hfd) |=>
        (dram_ras_n == 8'hfb) ##1 (dram_ras_n == 8'hf7) ##1 (dram_ras_n == 8'hef) ##1 (dram_ras_n == 8'hdf)
        ##1 (dram_ras_n == 8'hbf) ##1 (dram_ras_n == 8'h7f)) else $error("refresh walk broken");
    chk_ref_no_cas: assert property (ref_mark |-> dram_cas_n [*8]) else $error("column strobe in refresh");
    chk_ref_length: assert property (ref_mark |-> ##7 (dram_ras_n == '1) [*6])
        else $error("refresh too short");
    chk_ref_gap: assert property (ref_mark && seen_q |-> gap_q >= 9'd280 && gap_q <= 9'd320)
        else $error("refresh interval off");
    chk_cas_after_ras: assert property ($fell(dram_cas_n) |-> $past(dram_ras_n) != 8'hff)
        else $error("column before row");
    chk_we_in_cas: assert property (dram_we_n != 2'b11 |-> !dram_cas_n || !$past(dram_cas_n))
        else $error("write outside column");
    chk_err_lines: assert property (bdal_oe[17:16] != 2'b00 |-> bdal_oe[17:0] == '1 && bus_rply_oe)
        else $error("error lines without data");
    chk_data_oe: assert property (bdal_oe[15:0] != '0 |-> bus_rply_oe && bdal_oe[21:18] == 4'h0)
        else $error("data driven without reply");
    chk_led_clear: assert property ($fell(parity_led) |-> clr_q != 8'h00)
        else $error("error flag dropped alone");
    chk_rply_strobe: assert property ($rose(bus_rply_oe) |-> !bus_din_n || !bus_dout_n)
        else $error("reply without strobe");
    cov_refresh: cover property (ref_mark);
    cov_error: cover property (bdal_oe[17:16] == 2'b11);
    cov_write: cover property ($rose(bus_rply_oe) && !bus_dout_n);
endmodule
bind mpc_ctrl mpc_ctrl_assertions u_chk (.core_clk, .rst_b, .bus_din_n, .bus_dout_n, .bus_init_n, .bdal_oe,
    .bus_rply_oe, .dram_ras_n, .dram_cas_n, .dram_we_n, .parity_led);

// file: bench/testbench.sv
// Self-checking bench: bus master tasks, a word model and a status register model.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("Error %0t %h %h", $time, g, e); end end
module testbench;
    import mpc_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, big_chip = 1'b0, bus_sync_n = 1'b1, bus_din_n = 1'b1, bus_dout_n = 1'b1;
    logic bus_wtbt_n = 1'b1, bus_bs7_n = 1'b1, bus_bref_n = 1'b1, bus_init_n = 1'b1;
    logic bus_rply_out, bus_rply_oe, parity_led, dram_cas_n;
    logic [ADDR_W-1:0] bdal_in = '0, bdal_out, bdal_oe, oe_last, csr_a, a, b;
    logic [SW_W-1:0] start_addr_sw = 9'h1f0, end_addr_sw = 9'h1f8;
    logic [3:0] csr_sel_sw = 4'h0, ea_hi;
    logic [DRAM_AW-1:0] dram_addr;
    logic [BANKS-1:0] dram_ras_n;
    logic [1:0] dram_we_n;
    logic [DATA_W+1:0] dram_wdata, dram_rdata;
    logic [15:0] wq[$], rq[$], mdl[int], d;
    logic [6:0] ea_lo;
    bit ok;
    int fail_count = 0, checked = 0;
    // Free-running 25 MHz clock.
    always #20 core_clk = ~core_clk;
    mpc_ctrl dut (.core_clk, .rst_b, .bus_sync_n, .bus_din_n, .bus_dout_n, .bus_wtbt_n, .bus_bs7_n, .bus_bref_n,
        .bus_init_n, .bdal_in, .bdal_out, .bdal_oe, .bus_rply_out, .bus_rply_oe, .start_addr_sw, .end_addr_sw,
        .csr_sel_sw, .big_chip, .dram_addr, .dram_ras_n, .dram_cas_n, .dram_we_n, .dram_wdata, .dram_rdata,
        .parity_led);
    mpc_dram_model u_mem (.core_clk, .dram_addr, .dram_ras_n, .dram_cas_n, .dram_we_n, .dram_wdata, .dram_rdata);
    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Bounded wait for the reply level; a hard wait that runs out ends the run.
    task automatic wait_rply(input logic lvl, input bit hard, output bit got);
        int t;
        t = 0;
        do begin
            @(posedge core_clk);
            t++;
        end while (bus_rply_oe !== lvl && t < 100);
        got = (bus_rply_oe === lvl);
        if (!got && hard) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    // One dialogue: address, then n strobes (doubled for read-modify-write); strobes stay up until reply.
    task automatic xfer(input logic [ADDR_W-1:0] ad, input int n, input bit wr, bt, rmw, output bit got);
        bit w;
        got = 1'b1;
        @(posedge core_clk);
        bdal_in <= ad;
        bus_bs7_n <= !(&ad[21:13]);
        @(posedge core_clk);
        bus_sync_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < n * (rmw ? 2 : 1) && got; i++) begin
            w = wr || (rmw && i[0]);
            bdal_in <= w ? {6'h00, wq.pop_front()} : ~ad;
            bus_wtbt_n <= !(w && bt);
            bus_bref_n <= !(i < n - 1);
            if (w) bus_dout_n <= 1'b0;
            else bus_din_n <= 1'b0;
            wait_rply(1'b1, 1'b0, got);
            if (got && !w) rq.push_back(bdal_out[15:0]);
            oe_last = bdal_oe;
            bus_din_n <= 1'b1;
            bus_dout_n <= 1'b1;
            if (got) wait_rply(1'b0, 1'b1, got);
        end
        bus_sync_n <= 1'b1;
        bus_bref_n <= 1'b1;
        bus_wtbt_n <= 1'b1;
        bdal_in <= ~bdal_in;
    endtask
    task automatic wr_word(input logic [ADDR_W-1:0] ad, input logic [15:0] v);
        wq.push_back(v);
        xfer(ad, 1, 1'b1, 1'b0, 1'b0, ok);
        `CHK(ok, 1'b1)
    endtask
    task automatic rd_word(input logic [ADDR_W-1:0] ad, output logic [15:0] v);
        xfer(ad, 1, 1'b0, 1'b0, 1'b0, ok);
        `CHK(ok, 1'b1)
        v = ok ? rq.pop_front() : 16'h0000;
    endtask
    // Expected register image from the model's flags and the latched error address.
    function automatic logic [15:0] csr_exp(input bit b15, b14, b0);
        return {b15, b14, 2'b00, b14 ? {3'b000, ea_hi} : ea_lo, 4'h0, b0};
    endfunction
    initial begin
        void'($urandom(32'hef881848));
        csr_sel_sw = 4'($urandom_range(15));
        csr_a = {9'h1ff, CSR_BASE + {8'h00, csr_sel_sw, 1'b0}};
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd_word(csr_a, d);
        `CHK(d & 16'hc005, 16'h0000)
        wr_word(csr_a, 16'h0fff);
        rd_word(csr_a, d);
        `CHK(d, 16'h0fe5)
        wr_word(csr_a, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            a = {6'h3e, 16'($urandom) & 16'hfffe};
            d = 16'($urandom);
            wr_word(a, d);
            mdl[a >> 1] = d;
        end
        // Full-length block write, a high-lane byte write, a read-modify-write, then a block read.
        b = 22'h3e3000;
        for (int i = 0; i < BLOCK_MAX; i++) begin
            d = 16'($urandom);
            wq.push_back(d);
            mdl[(b >> 1) + i] = d;
        end
        xfer(b, BLOCK_MAX, 1'b1, 1'b0, 1'b0, ok);
        wq.push_back(16'ha5c3);
        xfer(b + 22'h1, 1, 1'b1, 1'b1, 1'b0, ok);
        mdl[b >> 1][15:8] = 8'ha5;
        wq.push_back(16'h0ff0);
        xfer(b + 22'h2, 1, 1'b0, 1'b0, 1'b1, ok);
        d = rq.pop_front();
        `CHK(d, mdl[(b >> 1) + 1])
        mdl[(b >> 1) + 1] = 16'h0ff0;
        xfer(b, BLOCK_MAX, 1'b0, 1'b0, 1'b0, ok);
        for (int i = 0; i < BLOCK_MAX; i++) begin
            d = rq.pop_front();
            `CHK(d, mdl[(b >> 1) + i])
        end
        for (int m = 0; m < 2; m++) begin
            foreach (mdl[k]) begin
                rd_word(22'(k * 2), d);
                `CHK(d, mdl[k])
            end
            big_chip <= 1'b1;
            foreach (mdl[k]) wr_word(22'(k * 2), mdl[k]);
        end
        `CHK(parity_led, 1'b0)
        xfer(22'h3f0000, 1, 1'b0, 1'b0, 1'b0, ok);
        `CHK(ok, 1'b0)
        xfer(22'h3dfffe, 1, 1'b0, 1'b0, 1'b0, ok);
        `CHK(ok, 1'b0)
        // Wrong parity stored on purpose, then read back with the error lines enabled.
        a = 22'h3e5a46;
        ea_lo = a[17:11];
        ea_hi = a[21:18];
        wr_word(csr_a, 16'h0005);
        wr_word(a, 16'hbeef);
        wr_word(csr_a, 16'h0001);
        rd_word(a, d);
        `CHK(d, 16'hbeef)
        `CHK(oe_last[17:16], 2'b11)
        `CHK(parity_led, 1'b1)
        rd_word(csr_a, d);
        `CHK(d, csr_exp(1, 0, 1))
        wq.push_back(16'hc000);
        xfer(csr_a + 22'h1, 1, 1'b1, 1'b1, 1'b0, ok);
        rd_word(csr_a, d);
        `CHK(d & 16'hf1ff, csr_exp(1, 1, 1) & 16'hf1ff)
        wq.push_back(16'h0000);
        xfer(csr_a + 22'h1, 1, 1'b1, 1'b1, 1'b0, ok);
        `CHK(parity_led, 1'b0)
        wq.push_back(16'hc000);
        xfer(csr_a + 22'h1, 1, 1'b1, 1'b1, 1'b0, ok);
        `CHK(parity_led, 1'b1)
        bus_init_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        bus_init_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd_word(csr_a, d);
        `CHK(d, csr_exp(0, 0, 0))
        repeat (700) @(posedge core_clk);
        tally_and_finish();
    end
endmodule
